// *** pmc_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - The two-bit charge pump code 0..3 selects 5, 10, 15 or 20 microamps.
// - In serial-programmed mode data goes out only while the transmit enable bit 2 is 1.
// - Bit 2 at both enable addresses is one shared control, written and read through either.
// - Three byte registers form the 24-bit LO word, frequency = word / 2^16 * crystal.
// - Plain FSK deviation is the 7-bit value times crystal / 8192.
// - Gaussian FSK deviation is the 4-bit value times crystal / 81920.
module pmc_regs
    import pmc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary bus address.
) (
    input  wire logic        MCLK,
    input  wire logic        ARST_N,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic        I2C_MODE,
    input  wire logic        MOD_FSK,
    input  wire logic        SHAPE_ON,
    input  wire logic        DATA_IN,
    output logic             TX_ACTIVE,
    output logic             TX_DATA,
    output logic [1:0]       CP_SEL,
    output logic [4:0]       CP_CURRENT_UA,
    output logic [23:0]      LO_LO_FREQUENCY_WORD_WORD,
    output logic [10:0]      DEV_STEPS
);

    // ****************************************************************
    // Reset release and pin sampling
    // ****************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    logic       scl_q;
    logic       sda_q;
    logic       scl_d;
    logic       sda_d;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_q <= SCL;
            sda_q <= SDA_IN;
            scl_d <= scl_q;
            sda_d <= sda_q;
        end
    end

    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    assign start_cond = scl_q && scl_d && sda_d && !sda_q;
    assign stop_cond  = scl_q && scl_d && !sda_d && sda_q;
    assign scl_rise   = scl_q && !scl_d;
    assign scl_fall   = !scl_q && scl_d;

    // ****************************************************************
    // Register storage and serial slave
    // ****************************************************************
    pmc_state_t  state, next_state;
    logic [3:0]  bitcnt, next_bitcnt;
    logic [7:0]  shreg, next_shreg;
    logic [7:0]  ptr, next_ptr;
    logic        rw, next_rw;
    logic        sda_oe, next_sda_oe;
    logic [1:0]  cp_sel, next_cp_sel;
    logic        txen, next_txen;
    logic [23:0] lo_word, next_lo_word;
    logic [6:0]  fsk_dev, next_fsk_dev;
    logic [3:0]  shaped_dev, next_shaped_dev;
    logic [7:0]  rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        case (ptr)
            PMC_OFS_CHARGE_PUMP: rd_byte = {6'h00, cp_sel};
            PMC_OFS_TX_ENABLE:   rd_byte = {5'h00, txen, 2'h0};
            PMC_OFS_TX_ALIAS:    rd_byte = {5'h00, txen, 2'h0};
            PMC_OFS_LO_HIGH:     rd_byte = lo_word[23:16];
            PMC_OFS_LO_MID:      rd_byte = lo_word[15:8];
            PMC_OFS_LO_LOW:      rd_byte = lo_word[7:0];
            PMC_OFS_FSK_DEV:     rd_byte = {1'b0, fsk_dev};
            PMC_OFS_SHAPED_DEV:  rd_byte = {4'h0, shaped_dev};
            default:             rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_state      = state;
        next_bitcnt     = bitcnt;
        next_shreg      = shreg;
        next_ptr        = ptr;
        next_rw         = rw;
        next_sda_oe     = sda_oe;
        next_cp_sel     = cp_sel;
        next_txen       = txen;
        next_lo_word    = lo_word;
        next_fsk_dev    = fsk_dev;
        next_shaped_dev = shaped_dev;
        if (start_cond) begin
            next_state  = PMC_ST_ADDR;
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_state  = PMC_ST_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                PMC_ST_ADDR, PMC_ST_REG, PMC_ST_WDATA: begin
                    if (scl_rise && bitcnt != PMC_BITS_PER_BYTE) begin
                        next_shreg  = {shreg[6:0], sda_q};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == PMC_BITS_PER_BYTE) begin
                        next_bitcnt = 4'h0;
                        next_sda_oe = 1'b1;
                        if (state == PMC_ST_ADDR) begin
                            next_rw    = shreg[0];
                            next_state = PMC_ST_ADDR_ACK;
                            if (shreg[7:1] != DEV_ADDR) begin
                                next_sda_oe = 1'b0;
                                next_state  = PMC_ST_IDLE;
                            end
                        end else if (state == PMC_ST_REG) begin
                            next_ptr   = shreg;
                            next_state = PMC_ST_REG_ACK;
                        end else begin
                            // Reserved and unused bits are dropped here.
                            case (ptr)
                                PMC_OFS_CHARGE_PUMP: next_cp_sel = shreg[1:0];
                                PMC_OFS_TX_ENABLE:   next_txen = shreg[PMC_TXEN_BIT];
                                PMC_OFS_TX_ALIAS:    next_txen = shreg[PMC_TXEN_BIT];
                                PMC_OFS_LO_HIGH:     next_lo_word[23:16] = shreg;
                                PMC_OFS_LO_MID:      next_lo_word[15:8] = shreg;
                                PMC_OFS_LO_LOW:      next_lo_word[7:0] = shreg;
                                PMC_OFS_FSK_DEV:     next_fsk_dev = shreg[6:0];
                                PMC_OFS_SHAPED_DEV:  next_shaped_dev = shreg[3:0];
                                default:             next_cp_sel = cp_sel;
                            endcase
                            next_ptr   = ptr + 8'h01;
                            next_state = PMC_ST_WDATA_ACK;
                        end
                    end
                end
                PMC_ST_ADDR_ACK, PMC_ST_REG_ACK, PMC_ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        if (state == PMC_ST_ADDR_ACK && rw) begin
                            next_shreg  = rd_byte;
                            next_sda_oe = !rd_byte[7];
                            next_state  = PMC_ST_RDATA;
                        end else if (state == PMC_ST_ADDR_ACK) begin
                            next_state = PMC_ST_REG;
                        end else begin
                            next_state = PMC_ST_WDATA;
                        end
                    end
                end
                PMC_ST_RDATA: begin
                    if (scl_fall && bitcnt == 4'h7) begin
                        next_bitcnt = 4'h0;
                        next_sda_oe = 1'b0;
                        next_ptr    = ptr + 8'h01;
                        next_state  = PMC_ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        next_bitcnt = bitcnt + 4'h1;
                        next_shreg  = {shreg[6:0], 1'b0};
                        next_sda_oe = !shreg[6];
                    end
                end
                PMC_ST_RDATA_ACK: begin
                    // A high level on the ninth clock ends the read.
                    if (scl_rise && sda_q) begin
                        next_state = PMC_ST_IDLE;
                    end else if (scl_fall) begin
                        next_shreg  = rd_byte;
                        next_sda_oe = !rd_byte[7];
                        next_state  = PMC_ST_RDATA;
                    end
                end
                default: next_state = state;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state      <= PMC_ST_IDLE;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            ptr        <= 8'h00;
            rw         <= 1'b0;
            sda_oe     <= 1'b0;
            cp_sel     <= PMC_RST_CP_SEL;
            txen       <= PMC_RST_TXEN;
            lo_word    <= {PMC_RST_LO_HIGH, PMC_RST_LO_MID, PMC_RST_LO_LOW};
            fsk_dev    <= PMC_RST_FSK_DEV;
            shaped_dev <= PMC_RST_SHAPED_DEV;
        end else begin
            state      <= next_state;
            bitcnt     <= next_bitcnt;
            shreg      <= next_shreg;
            ptr        <= next_ptr;
            rw         <= next_rw;
            sda_oe     <= next_sda_oe;
            cp_sel     <= next_cp_sel;
            txen       <= next_txen;
            lo_word    <= next_lo_word;
            fsk_dev    <= next_fsk_dev;
            shaped_dev <= next_shaped_dev;
        end
    end

    // ****************************************************************
    // Control outputs
    // ****************************************************************
    logic        next_tx_active;
    logic        next_tx_data;
    logic [4:0]  next_cp_ua;
    logic [10:0] next_dev_steps;

    // Deviation is given in steps of crystal / 81920 for both modes.
    always_comb begin
        next_tx_active = I2C_MODE && txen;
        next_tx_data   = I2C_MODE && txen && DATA_IN;
        next_cp_ua     = 5'((5'(cp_sel) + 5'h01) * PMC_CP_UA_STEP);
        next_dev_steps = 11'h000;
        if (MOD_FSK && SHAPE_ON) begin
            next_dev_steps = 11'(shaped_dev);
        end else if (MOD_FSK) begin
            next_dev_steps = 11'(11'(fsk_dev) * PMC_DEV_PLAIN_SCALE);
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            SDA_OUT       <= 1'b0;
            SDA_OE        <= 1'b0;
            TX_ACTIVE     <= 1'b0;
            TX_DATA       <= 1'b0;
            CP_SEL        <= PMC_RST_CP_SEL;
            CP_CURRENT_UA <= PMC_CP_UA_STEP;
            LO_LO_FREQUENCY_WORD_WORD  <= {PMC_RST_LO_HIGH, PMC_RST_LO_MID, PMC_RST_LO_LOW};
            DEV_STEPS     <= 11'h000;
        end else begin
            SDA_OUT       <= 1'b0;
            SDA_OE        <= next_sda_oe;
            TX_ACTIVE     <= next_tx_active;
            TX_DATA       <= next_tx_data;
            CP_SEL        <= next_cp_sel;
            CP_CURRENT_UA <= next_cp_ua;
            LO_LO_FREQUENCY_WORD_WORD  <= next_lo_word;
            DEV_STEPS     <= next_dev_steps;
        end
    end

endmodule

// *** pmc_pkg.sv ***
package pmc_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] PMC_OFS_CHARGE_PUMP = 8'h09;
    localparam logic [7:0] PMC_OFS_TX_ENABLE   = 8'h0a;
    localparam logic [7:0] PMC_OFS_LO_HIGH     = 8'h0b;
    localparam logic [7:0] PMC_OFS_LO_MID      = 8'h0c;
    localparam logic [7:0] PMC_OFS_LO_LOW      = 8'h0d;
    localparam logic [7:0] PMC_OFS_FSK_DEV     = 8'h0e;
    localparam logic [7:0] PMC_OFS_SHAPED_DEV  = 8'h0f;
    localparam logic [7:0] PMC_OFS_TX_ALIAS    = 8'h10;

    // ****************************************************************
    // Field positions and values after reset
    // ****************************************************************
    localparam int         PMC_TXEN_BIT        = 2;
    localparam logic [1:0] PMC_RST_CP_SEL      = 2'h0;
    localparam logic       PMC_RST_TXEN        = 1'h0;
    localparam logic [7:0] PMC_RST_LO_HIGH     = 8'h13;
    localparam logic [7:0] PMC_RST_LO_MID      = 8'hb0;
    localparam logic [7:0] PMC_RST_LO_LOW      = 8'h00;
    localparam logic [6:0] PMC_RST_FSK_DEV     = 7'h28;
    localparam logic [3:0] PMC_RST_SHAPED_DEV  = 4'h4;

    // ****************************************************************
    // Scaling of decoded outputs
    // ****************************************************************
    localparam logic [4:0]  PMC_CP_UA_STEP     = 5'h05;
    localparam int          PMC_LO_FRAC_BITS   = 16;
    localparam int          PMC_DEV_PLAIN_DIV  = 8192;
    localparam int          PMC_DEV_SHAPED_DIV = 81920;
    localparam logic [10:0] PMC_DEV_PLAIN_SCALE = 11'(PMC_DEV_SHAPED_DIV / PMC_DEV_PLAIN_DIV);

    // ****************************************************************
    // Serial interface
    // ****************************************************************
    localparam logic [3:0] PMC_BITS_PER_BYTE   = 4'h8;

    typedef enum logic [3:0] {
        PMC_ST_IDLE      = 4'b0000,
        PMC_ST_ADDR      = 4'b0001,
        PMC_ST_ADDR_ACK  = 4'b0010,
        PMC_ST_REG       = 4'b0011,
        PMC_ST_REG_ACK   = 4'b0100,
        PMC_ST_WDATA     = 4'b0101,
        PMC_ST_WDATA_ACK = 4'b0110,
        PMC_ST_RDATA     = 4'b0111,
        PMC_ST_RDATA_ACK = 4'b1000
    } pmc_state_t;

endpackage

// *** pmc_regs_asserts.sv ***
`timescale 1ns/1ps
module pmc_regs_asserts
    import pmc_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        ARST_N,
    input wire logic        SCL,
    input wire logic        SDA_OE,
    input wire logic        I2C_MODE,
    input wire logic        MOD_FSK,
    input wire logic        SHAPE_ON,
    input wire logic        DATA_IN,
    input wire logic        TX_ACTIVE,
    input wire logic        TX_DATA,
    input wire logic [1:0]  CP_SEL,
    input wire logic [4:0]  CP_CURRENT_UA,
    input wire logic [23:0] LO_LO_FREQUENCY_WORD_WORD,
    input wire logic [10:0] DEV_STEPS
);
    // ****************************************************************
    // Checks on decoded controls
    // ****************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    // A register write lands on the edge where the acknowledge starts.
    sequence reg_commit;
        $rose(SDA_OE) && !SCL;
    endsequence

    a_cp_current_decode: assert property (
        1'b1 |=> CP_CURRENT_UA == PMC_CP_UA_STEP * ({3'h0, $past(CP_SEL)} + 5'h01))
        else $error("charge pump current does not match its code");
    a_cp_sel_commit: assert property (
        !$stable(CP_SEL) |-> reg_commit)
        else $error("charge pump code changed outside a write");
    a_tx_mode_gate: assert property (
        !I2C_MODE |=> !TX_ACTIVE && !TX_DATA)
        else $error("transmit active outside serial mode");
    a_tx_data_follow: assert property (
        TX_DATA == (TX_ACTIVE && $past(DATA_IN)))
        else $error("transmit data does not follow input data");
    a_lo_word_bytes: assert property (
        !$stable(LO_LO_FREQUENCY_WORD_WORD) |-> reg_commit ##0
            $countones({$stable(LO_LO_FREQUENCY_WORD_WORD[23:16]), $stable(LO_LO_FREQUENCY_WORD_WORD[15:8]),
                        $stable(LO_LO_FREQUENCY_WORD_WORD[7:0])}) >= 2)
        else $error("LO word changed outside a single byte write");
    a_dev_plain_range: assert property (
        MOD_FSK && !SHAPE_ON |=> DEV_STEPS % 11'h00a == 11'h000 && DEV_STEPS <= 11'h4f6)
        else $error("plain deviation out of range");
    a_dev_shaped_range: assert property (
        MOD_FSK && SHAPE_ON |=> DEV_STEPS <= 11'h00f)
        else $error("shaped deviation out of range");
    a_dev_off_zero: assert property (
        !MOD_FSK |=> DEV_STEPS == 11'h000)
        else $error("deviation not zero without FSK");
endmodule

bind pmc_regs pmc_regs_asserts i_pmc_regs_asserts (
    .MCLK(MCLK), .ARST_N(ARST_N), .SCL(SCL), .SDA_OE(SDA_OE), .I2C_MODE(I2C_MODE),
    .MOD_FSK(MOD_FSK), .SHAPE_ON(SHAPE_ON), .DATA_IN(DATA_IN), .TX_ACTIVE(TX_ACTIVE),
    .TX_DATA(TX_DATA), .CP_SEL(CP_SEL), .CP_CURRENT_UA(CP_CURRENT_UA),
    .LO_LO_FREQUENCY_WORD_WORD(LO_LO_FREQUENCY_WORD_WORD), .DEV_STEPS(DEV_STEPS)
);

// *** pmc_host.sv ***
`timescale 1ns/1ps
module pmc_host
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic clk,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    // ****************************************************************
    // Serial bus master
    // ****************************************************************
    logic drv = 1'b1;
    logic ok  = 1'b1;
    // Bus address sent by the master; a test may alter it to address another device.
    logic [6:0] addr = DEV_ADDR;
    int   ph  = 5;
    initial scl = 1'b1;
    // The line has a pull-up, so it is high unless a party pulls it low.
    assign sda = drv & ~sda_oe;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put_bit(input logic b);
        drv = b;
        tick(ph);
        scl = 1'b1;
        tick(2 * ph);
        scl = 1'b0;
        tick(ph);
    endtask
    task automatic get_bit(output logic b);
        drv = 1'b1;
        tick(ph);
        scl = 1'b1;
        tick(ph);
        b = sda;
        tick(ph);
        scl = 1'b0;
        tick(ph);
    endtask
    task automatic start();
        drv = 1'b1;
        tick(ph);
        scl = 1'b1;
        tick(ph);
        drv = 1'b0;
        tick(ph);
        scl = 1'b0;
        tick(ph);
    endtask
    task automatic stop();
        drv = 1'b0;
        tick(ph);
        scl = 1'b1;
        tick(ph);
        drv = 1'b1;
        tick(2 * ph);
    endtask
    task automatic send(input logic [7:0] v);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(b);
        if (b) ok = 1'b0;
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        ok = 1'b1;
        start();
        send({addr, 1'b0});
        send(a);
        send(d);
        stop();
    endtask
    task automatic write2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
        ok = 1'b1;
        start();
        send({addr, 1'b0});
        send(a);
        send(d0);
        send(d1);
        stop();
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        ok = 1'b1;
        start();
        send({addr, 1'b0});
        send(a);
        start();
        send({addr, 1'b1});
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop();
    endtask
    // The master acknowledges the first byte, so the device sends a second one.
    task automatic read2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
        ok = 1'b1;
        start();
        send({addr, 1'b0});
        send(a);
        start();
        send({addr, 1'b1});
        for (int i = 7; i >= 0; i--) get_bit(d0[i]);
        put_bit(1'b0);
        for (int i = 7; i >= 0; i--) get_bit(d1[i]);
        put_bit(1'b1);
        stop();
    endtask
endmodule

// *** tb_pmc_regs.sv ***
`timescale 1ns/1ps
module tb_pmc_regs import pmc_pkg::*;;
    logic        MCLK = 1'b0;
    logic        ARST_N = 1'b0;
    logic        I2C_MODE = 1'b0;
    logic        MOD_FSK = 1'b0;
    logic        SHAPE_ON = 1'b0;
    logic        DATA_IN = 1'b1;
    logic        scl, sda, sda_oe, tx_active, tx_data;
    logic [1:0]  cp_sel;
    logic [4:0]  cp_ua;
    logic [23:0] lo_word;
    logic [10:0] dev_steps;
    logic [7:0]  rd;
    logic [7:0]  rd2;
    logic        sda_out;
    logic [23:0] lo_exp = 24'h13b000;
    logic [7:0]  rst_val [8] = '{8'h00, 8'h00, 8'h13, 8'hb0, 8'h00, 8'h28, 8'h04, 8'h00};
    int          n_fail = 0;
    int          check_count = 0;

    always #2 MCLK = ~MCLK;

    pmc_regs i_pmc_regs (.MCLK(MCLK), .ARST_N(ARST_N), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .I2C_MODE(I2C_MODE), .MOD_FSK(MOD_FSK), .SHAPE_ON(SHAPE_ON),
        .DATA_IN(DATA_IN), .TX_ACTIVE(tx_active), .TX_DATA(tx_data), .CP_SEL(cp_sel),
        .CP_CURRENT_UA(cp_ua), .LO_LO_FREQUENCY_WORD_WORD(lo_word), .DEV_STEPS(dev_steps));
    pmc_host i_pmc_host (.clk(MCLK), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    // ****************************************************************
    // Checking and access tasks
    // ****************************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_pmc_host.read(a, rd);
        check({16'h0, rd}, {16'h0, exp});
        check({23'h0, i_pmc_host.ok}, 24'h000001);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_pmc_host.write(a, d);
        check({23'h0, i_pmc_host.ok}, 24'h000001);
    endtask
    task automatic step();
        repeat (2) @(posedge MCLK);
        #1;
    endtask

    initial begin
        repeat (90000) @(posedge MCLK);
        n_fail++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge MCLK);
        #1;
        ARST_N = 1'b1;
        repeat (3) step();
        check(lo_word, 24'h13b000);
        check(24'(cp_ua), 24'h000005);
        for (int i = 0; i < 8; i++) rd_chk(PMC_OFS_CHARGE_PUMP + 8'(i), rst_val[i]);
        for (int c = 0; c < 4; c++) begin
            wr(PMC_OFS_CHARGE_PUMP, 8'h3c | 8'(c));
            check(24'(cp_ua), 24'(5 * (c + 1)));
            check(24'(cp_sel), 24'(c));
            rd_chk(PMC_OFS_CHARGE_PUMP, 8'(c));
        end
        I2C_MODE = 1'b1;
        wr(PMC_OFS_TX_ALIAS, 8'hfc);
        rd_chk(PMC_OFS_TX_ENABLE, 8'h04);
        check({22'h0, tx_active, tx_data}, 24'h000003);
        DATA_IN = 1'b0;
        step();
        check({22'h0, tx_active, tx_data}, 24'h000002);
        I2C_MODE = 1'b0;
        step();
        check({23'h0, tx_active}, 24'h000000);
        I2C_MODE = 1'b1;
        wr(PMC_OFS_TX_ENABLE, 8'h00);
        rd_chk(PMC_OFS_TX_ALIAS, 8'h00);
        check({23'h0, tx_active}, 24'h000000);
        for (int b = 0; b < 3; b++) begin
            lo_exp[23 - 8 * b -: 8] = 8'(24'ha55a3c >> (16 - 8 * b));
            wr(PMC_OFS_LO_HIGH + 8'(b), lo_exp[23 - 8 * b -: 8]);
            check(lo_word, lo_exp);
        end
        rd_chk(PMC_OFS_LO_MID, 8'h5a);
        // A two-byte burst relies on the pointer stepping after each byte.
        i_pmc_host.write2(PMC_OFS_LO_MID, 8'h12, 8'h34);
        check({23'h0, i_pmc_host.ok}, 24'h000001);
        check(lo_word, 24'ha51234);
        i_pmc_host.read2(PMC_OFS_LO_HIGH, rd, rd2);
        check({8'h0, rd, rd2}, 24'h00a512);
        check({23'h0, i_pmc_host.ok}, 24'h000001);
        // A frame for another bus address is refused and changes nothing.
        i_pmc_host.addr = i_pmc_host.addr ^ 7'h01;
        i_pmc_host.write(PMC_OFS_LO_LOW, 8'hff);
        check({23'h0, i_pmc_host.ok}, 24'h000000);
        check(lo_word, 24'ha51234);
        i_pmc_host.addr = i_pmc_host.addr ^ 7'h01;
        MOD_FSK = 1'b1;
        wr(PMC_OFS_FSK_DEV, 8'hff);
        rd_chk(PMC_OFS_FSK_DEV, 8'h7f);
        check(24'(dev_steps), 24'(127 * PMC_DEV_SHAPED_DIV / PMC_DEV_PLAIN_DIV));
        i_pmc_host.ph = 9;
        wr(PMC_OFS_SHAPED_DEV, 8'hfa);
        SHAPE_ON = 1'b1;
        rd_chk(PMC_OFS_SHAPED_DEV, 8'h0a);
        check(24'(dev_steps), 24'h00000a);
        MOD_FSK = 1'b0;
        step();
        check(24'(dev_steps), 24'h000000);
        wr(8'h30, 8'hff);
        check(lo_word, 24'ha51234);
        rd_chk(8'h30, 8'h00);
        check(24'(sda_out), 24'h000000);
        ARST_N = 1'b0;
        step();
        ARST_N = 1'b1;
        repeat (3) step();
        check(lo_word, 24'h13b000);
        check(24'(cp_ua), 24'h000005);
        conclude();
    end
endmodule
